// [rtcwg_pkg.sv]
// Purpose: Shared constants and types of the RTC waveform unit
// Assumes: 100 MHz system clock, 32.768 kHz slow clock pin
// Notes:   Byte offsets of the APB register words
package rtcwg_pkg;

  localparam int          CLK_MHZ      = 100;
  localparam int          PULSE_US     = 15;
  localparam int          PULSE_CYC    = PULSE_US * CLK_MHZ;
  localparam int          CAL_PERIOD_S = 20;

  localparam logic [11:0] ADDR_MODE    = 12'h000;
  localparam logic [11:0] ADDR_STAT    = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_TIME    = 12'h00C;

  // Mode register fields
  localparam int          NEG_BIT      = 1;
  localparam int          AMT_LSB      = 8;
  localparam int          COARSE_BIT   = 15;
  localparam int          SELA_LSB     = 16;
  localparam int          SELB_LSB     = 20;

  // Status bits
  localparam int          ST_ALARM     = 0;
  localparam int          ST_SEC       = 1;
  localparam int          ST_W         = 2;

  // Prescaler taps
  localparam int          TAP_1HZ      = 14;
  localparam int          TAP_32HZ     = 9;
  localparam int          TAP_64HZ     = 8;
  localparam int          TAP_512HZ    = 5;
  localparam int          COARSE_SHIFT = 2;

  typedef enum logic [2:0] {
    SEL_OFF    = 3'h0,
    SEL_1HZ    = 3'h1,
    SEL_32HZ   = 3'h2,
    SEL_64HZ   = 3'h3,
    SEL_512HZ  = 3'h4,
    SEL_TOGGLE = 3'h5,
    SEL_ALARM  = 3'h6,
    SEL_PULSE  = 3'h7
  } rtcwg_sel_t;

  typedef struct packed {
    logic [6:0] amount;
    logic       coarse;
    logic       negPpm;
  } rtcwg_corr_t;

  typedef struct packed {
    logic hz1;
    logic hz32;
    logic hz64;
    logic hz512;
    logic alarm;
    logic pulse;
  } rtcwg_src_t;

endpackage : rtcwg_pkg

// [rtcwg_top.sv]
// Purpose: Waveform outputs and crystal calibration of the RTC
// Assumes: APB slave on clk_sys, slow clock arrives as a pin
// Notes:   Two selectable outputs, sticky status with mask
`timescale 1ns/1ps
module rtcwg_top (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        slowClkPin,
  input  wire logic        backupPowerOk,
  input  wire logic        alarmEvent,
  output logic             waveOutA,
  output logic             waveOutB,
  output logic             waveLineSelA,
  output logic             waveLineSelB,
  output logic             irq
);

  // Pin synchronisers
  logic        slowS1_q;
  logic        slowS2_q;
  logic        slowS3_q;
  logic        bkpS1_q;
  logic        bkpS2_q;
  logic        slowTick;

  // Registers
  rtcwg_pkg::rtcwg_corr_t corr_q;
  logic [2:0]  sel_q [2];
  logic [rtcwg_pkg::ST_W-1:0] stat_q;
  logic [rtcwg_pkg::ST_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic        err_q;

  // Time base
  logic [14:0] presc_q;
  logic [5:0]  fixDiv_q;
  logic [8:0]  adjLeft_q;
  logic [4:0]  calSec_q;
  logic [31:0] secCount_q;
  logic [15:0] pulseCnt_q;
  logic [15:0] prescSum;
  logic [1:0]  prescStep;
  logic        secWrap;
  logic [8:0]  adjLoad;

  // Waveform state
  logic        tog_q  [2];
  logic        wave_q [2];
  rtcwg_pkg::rtcwg_src_t src;

  // Bus decode
  logic        wrEn;
  logic        setup;
  logic [rtcwg_pkg::ST_W-1:0] statSet;
  logic [rtcwg_pkg::ST_W-1:0] statClr;

  // Source multiplexer shared by both outputs
  // Every code is legal, so the case needs no default
  function automatic logic waveMux(
    input logic [2:0]            sel,
    input logic                  tog,
    input rtcwg_pkg::rtcwg_src_t s
  );
    logic r;
    r = 1'b0;
    unique case (rtcwg_pkg::rtcwg_sel_t'(sel))
      rtcwg_pkg::SEL_OFF:    r = 1'b0;
      rtcwg_pkg::SEL_1HZ:    r = s.hz1;
      rtcwg_pkg::SEL_32HZ:   r = s.hz32;
      rtcwg_pkg::SEL_64HZ:   r = s.hz64;
      rtcwg_pkg::SEL_512HZ:  r = s.hz512;
      rtcwg_pkg::SEL_TOGGLE: r = tog;
      rtcwg_pkg::SEL_ALARM:  r = s.alarm;
      rtcwg_pkg::SEL_PULSE:  r = s.pulse;
    endcase
    return r;
  endfunction : waveMux

  // Two-flop synchronisers, third flop for edge detect
  // Async pins settle in the first flop before any logic reads them
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slowS1_q <= 1'b0;
      slowS2_q <= 1'b0;
      slowS3_q <= 1'b0;
      bkpS1_q  <= 1'b0;
      bkpS2_q  <= 1'b0;
    end else begin
      slowS1_q <= slowClkPin;
      slowS2_q <= slowS1_q;
      slowS3_q <= slowS2_q;
      bkpS1_q  <= backupPowerOk;
      bkpS2_q  <= bkpS1_q;
    end
  end

  // One pulse per slow clock rising edge
  assign slowTick = slowS2_q & ~slowS3_q;

  // Adjustment ticks per period, coarse range scales by four
  assign adjLoad = corr_q.coarse
                 ? 9'(corr_q.amount) << rtcwg_pkg::COARSE_SHIFT
                 : 9'(corr_q.amount);

  // Step of the corrected prescaler on a slow tick
  // Steps of two shorten the second, steps of zero stretch it
  always_comb begin
    prescStep = 2'h1;
    if (adjLeft_q != 9'h000) begin
      prescStep = corr_q.negPpm ? 2'h2 : 2'h0;
    end
  end

  assign prescSum = {1'b0, presc_q} + {14'h0000, prescStep};
  assign secWrap  = slowTick & prescSum[15];

  // Corrected prescaler, never stopped by register writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      presc_q <= 15'h0000;
    end else if (slowTick) begin
      presc_q <= prescSum[14:0];
    end
  end

  // Uncorrected divider keeps 512 Hz free of trimming
  // Kept apart so a trim never shows on the fastest output
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fixDiv_q <= 6'h00;
    end else if (slowTick) begin
      fixDiv_q <= fixDiv_q + 6'h01;
    end
  end

  // Calibration period and pending adjustment count
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      calSec_q  <= 5'h00;
      adjLeft_q <= 9'h000;
    end else begin
      if (secWrap) begin
        if (calSec_q == 5'(rtcwg_pkg::CAL_PERIOD_S - 1)) begin
          calSec_q  <= 5'h00;
          adjLeft_q <= adjLoad;
        end else begin
          calSec_q <= calSec_q + 5'h01;
        end
      end else if (slowTick && adjLeft_q != 9'h000) begin
        adjLeft_q <= adjLeft_q - 9'h001;
      end
    end
  end

  // Seconds counter read back by software
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      secCount_q <= 32'h0000_0000;
    end else if (secWrap) begin
      secCount_q <= secCount_q + 32'h0000_0001;
    end
  end

  // 15 us pulse started at each second boundary
  // Length is counted in system clock cycles, not slow ticks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pulseCnt_q <= 16'h0000;
    end else if (secWrap) begin
      pulseCnt_q <= 16'(rtcwg_pkg::PULSE_CYC);
    end else if (pulseCnt_q != 16'h0000) begin
      pulseCnt_q <= pulseCnt_q - 16'h0001;
    end
  end

  // Waveform sources: taps of the slow clock chain, the second pulse and the alarm status bit
  always_comb begin
    src.hz1   = presc_q[rtcwg_pkg::TAP_1HZ];
    src.hz32  = presc_q[rtcwg_pkg::TAP_32HZ];
    src.hz64  = presc_q[rtcwg_pkg::TAP_64HZ];
    src.hz512 = fixDiv_q[rtcwg_pkg::TAP_512HZ];
    src.alarm = stat_q[rtcwg_pkg::ST_ALARM];
    src.pulse = pulseCnt_q != 16'h0000;
  end

  // Per-output toggle and output flop
  // Toggle only counts alarms while its selector is chosen
  for (genvar i = 0; i < 2; i++) begin : g_out
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        tog_q[i] <= 1'b0;
      end else if (alarmEvent &&
                   sel_q[i] == rtcwg_pkg::SEL_TOGGLE) begin
        tog_q[i] <= ~tog_q[i];
      end
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        wave_q[i] <= 1'b0;
      end else begin
        wave_q[i] <= waveMux(sel_q[i], tog_q[i], src);
      end
    end
  end

  // No low-power input gates the outputs
  assign waveOutA     = wave_q[0];
  assign waveOutB     = wave_q[1];
  assign waveLineSelA = sel_q[0] != 3'h0;
  assign waveLineSelB = sel_q[1] != 3'h0;

  // APB phases
  // Zero wait states: ready follows the access phase directly
  assign setup   = psel & ~penable;
  assign wrEn    = psel & penable & pwrite;
  assign pready  = psel & penable;
  assign prdata  = rdata_q;
  assign pslverr = psel & penable & err_q;

  // Mode register: selectors and correction
  // Loss of backup power wipes the trim; selectors keep their value
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sel_q[0] <= 3'h0;
      sel_q[1] <= 3'h0;
      corr_q   <= '0;
    end else begin
      if (wrEn && paddr == rtcwg_pkg::ADDR_MODE) begin
        sel_q[0]      <= pwdata[rtcwg_pkg::SELA_LSB +: 3];
        sel_q[1]      <= pwdata[rtcwg_pkg::SELB_LSB +: 3];
        corr_q.amount <= pwdata[rtcwg_pkg::AMT_LSB +: 7];
        corr_q.coarse <= pwdata[rtcwg_pkg::COARSE_BIT];
        corr_q.negPpm <= pwdata[rtcwg_pkg::NEG_BIT];
      end
      if (!bkpS2_q) begin
        corr_q <= '0;
      end
    end
  end

  // Status events and write-one-to-clear
  always_comb begin
    statSet = '0;
    statSet[rtcwg_pkg::ST_ALARM] = alarmEvent;
    statSet[rtcwg_pkg::ST_SEC]   = secWrap;
    statClr = '0;
    if (wrEn && paddr == rtcwg_pkg::ADDR_STAT) begin
      statClr = pwdata[rtcwg_pkg::ST_W-1:0];
    end
  end

  // Set wins over a clear in the same cycle
  // An event in the clearing cycle stays set, so no alarm is lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~statClr) | statSet;
    end
  end

  // Interrupt mask
  // Same layout as the status word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_q <= '0;
    end else if (wrEn && paddr == rtcwg_pkg::ADDR_MASK) begin
      mask_q <= pwdata[rtcwg_pkg::ST_W-1:0];
    end
  end

  // Level interrupt
  // Registered, so it trails the status bit by one cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  // Read data and error captured in the setup cycle
  // Early capture lets the access phase answer with no wait state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      unique case (paddr)
        rtcwg_pkg::ADDR_MODE: begin
          rdata_q[rtcwg_pkg::SELA_LSB +: 3]  <= sel_q[0];
          rdata_q[rtcwg_pkg::SELB_LSB +: 3]  <= sel_q[1];
          rdata_q[rtcwg_pkg::AMT_LSB +: 7]   <= corr_q.amount;
          rdata_q[rtcwg_pkg::COARSE_BIT]     <= corr_q.coarse;
          rdata_q[rtcwg_pkg::NEG_BIT]        <= corr_q.negPpm;
        end
        rtcwg_pkg::ADDR_STAT: begin
          rdata_q[rtcwg_pkg::ST_W-1:0] <= stat_q;
        end
        rtcwg_pkg::ADDR_MASK: begin
          rdata_q[rtcwg_pkg::ST_W-1:0] <= mask_q;
        end
        rtcwg_pkg::ADDR_TIME: begin
          rdata_q <= secCount_q;
        end
        default: begin
          err_q <= 1'b1;
        end
      endcase
    end
  end

endmodule : rtcwg_top

// [rtcwg_asserts.sv]
// Purpose: Port checks of the RTC waveform unit
// Assumes: Selector and mask copies rebuilt from APB writes
// Notes:   Bound to rtcwg_top at the foot of this file
`timescale 1ns/1ps
module rtcwg_asserts (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        alarmEvent,
  input wire logic        waveOutA,
  input wire logic        waveOutB,
  input wire logic        waveLineSelA,
  input wire logic        waveLineSelB,
  input wire logic        irq
);
  logic [2:0] selA_q;
  logic [2:0] selB_q;
  logic       mask_q;
  logic       wrEn;
  // Write strobe of the access phase
  assign wrEn = psel && penable && pwrite;
  // Shadow copies of the selectors and alarm mask
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      selA_q <= 3'h0;
      selB_q <= 3'h0;
      mask_q <= 1'b0;
    end else if (wrEn && paddr == rtcwg_pkg::ADDR_MODE) begin
      selA_q <= pwdata[rtcwg_pkg::SELA_LSB +: 3];
      selB_q <= pwdata[rtcwg_pkg::SELB_LSB +: 3];
    end else if (wrEn && paddr == rtcwg_pkg::ADDR_MASK) begin
      mask_q <= pwdata[rtcwg_pkg::ST_ALARM];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Mirror output drops soon after the flag is cleared
  sequence sClr;
    ##[1:3] !waveOutB;
  endsequence
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_unmapped_err: assert property (psel && penable && paddr > rtcwg_pkg::ADDR_TIME
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access accepted");
  a_off_low: assert property (selA_q == 3'h0 && $past(selA_q) == 3'h0 |-> !waveOutA)
    else $error("output A not held low");
  a_line_sel_a: assert property ($stable(selA_q) |-> waveLineSelA == (selA_q != 3'h0))
    else $error("line A hand-over wrong");
  a_line_sel_b: assert property ($stable(selB_q) |-> waveLineSelB == (selB_q != 3'h0))
    else $error("line B hand-over wrong");
  a_toggle_flip: assert property (alarmEvent && selA_q == rtcwg_pkg::SEL_TOGGLE
    |-> ##[1:3] $changed(waveOutA)) else $error("toggle output did not flip");
  a_mirror_rise: assert property (alarmEvent && selB_q == rtcwg_pkg::SEL_ALARM
    |-> ##[1:3] waveOutB) else $error("mirror output not set");
  a_mirror_clear: assert property (wrEn && paddr == rtcwg_pkg::ADDR_STAT && pwdata[0]
    && !alarmEvent && selB_q == rtcwg_pkg::SEL_ALARM |-> sClr) else $error("mirror not cleared");
  a_irq_raise: assert property (alarmEvent && mask_q |-> ##[1:3] irq)
    else $error("interrupt not raised");
  a_irq_masked: assert property (wrEn && paddr == rtcwg_pkg::ADDR_MASK
    && pwdata == 32'h0000_0000 |-> ##2 !irq) else $error("masked interrupt stays high");
endmodule : rtcwg_asserts

bind rtcwg_top rtcwg_asserts i_rtcwg_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .alarmEvent(alarmEvent),
  .waveOutA(waveOutA), .waveOutB(waveOutB), .waveLineSelA(waveLineSelA),
  .waveLineSelB(waveLineSelB), .irq(irq));

// [rtcwg_xtal.sv]
// Purpose: Slow crystal model feeding the unit
// Assumes: Free-running oscillator, phase unrelated to clk_sys
// Notes:   Default half period is 32.768 kHz; benches shorten it
`timescale 1ns/1ps
module rtcwg_xtal #(
  parameter real HALF_NS = 15258.789
) (
  output logic slowClk
);
  // Oscillator offset from the system clock edges
  initial begin
    slowClk = 1'b0;
    #3;
    forever #(HALF_NS) slowClk = ~slowClk;
  end
endmodule : rtcwg_xtal

// [rtcwg_tb.sv]
// Purpose: Self-checking bench of the RTC waveform unit
// Assumes: Crystal sped up to one tick every 6 clk_sys cycles
// Notes:   Second wrap is out of reach within the run length
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 6;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        slowClkPin;
  logic        backupPowerOk = 1'b1;
  logic        alarmEvent = 1'b0;
  logic        waveOutA;
  logic        waveOutB;
  logic        waveLineSelA;
  logic        waveLineSelB;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          checked = 0;
  // System clock of 100 MHz
  always #5 clk_sys = ~clk_sys;
  rtcwg_top i_rtcwg_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .slowClkPin(slowClkPin),
    .backupPowerOk(backupPowerOk), .alarmEvent(alarmEvent), .waveOutA(waveOutA),
    .waveOutB(waveOutB), .waveLineSelA(waveLineSelA), .waveLineSelB(waveLineSelB),
    .irq(irq));
  rtcwg_xtal #(.HALF_NS(30.0)) i_rtcwg_xtal (.slowClk(slowClkPin));
  task automatic chkW(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chkW
  // One APB transfer, then two settling edges
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : apb
  task automatic rdw(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chkW(rd, e);
  endtask : rdw
  // Period of one output, rising edge to rising edge
  task automatic per(input logic b, input int tap);
    int   n;
    int   r;
    int   c;
    logic v;
    logic o;
    n = 0;
    r = 0;
    c = 0;
    o = 1'b1;
    while (r < 2 && n < 40000) begin
      @(posedge clk_sys);
      v = b ? waveOutB : waveOutA;
      if (v === 1'b1 && o === 1'b0) r++;
      if (r == 1) c++;
      o = v;
      n++;
    end
    chkW(c, 2 * TICK * (1 << tap));
  endtask : per
  task automatic results;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // Watchdog against a hang
  initial begin
    #1_000_000;
    mismatches++;
    results;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdw(rtcwg_pkg::ADDR_MODE, 32'h0000_0000);
    chkW(waveOutA, 1'b0);
    chkW(waveLineSelA, 1'b0);
    rdw(12'h010, 32'h0000_0000);
    chkW(err, 1'b1);
    for (int k = 2; k < 5; k++) begin
      apb(1'b1, rtcwg_pkg::ADDR_MODE, (k << 16) | ((k - 1) << 20));
      chkW(waveLineSelA, 1'b1);
      per(1'b0, k == 2 ? rtcwg_pkg::TAP_32HZ : k == 3 ? rtcwg_pkg::TAP_64HZ
              : rtcwg_pkg::TAP_512HZ);
    end
    per(1'b1, rtcwg_pkg::TAP_64HZ);
    apb(1'b1, rtcwg_pkg::ADDR_MODE, 32'h0004_FF02);
    rdw(rtcwg_pkg::ADDR_MODE, 32'h0004_FF02);
    per(1'b0, rtcwg_pkg::TAP_512HZ);
    backupPowerOk <= 1'b0;
    per(1'b0, rtcwg_pkg::TAP_512HZ);
    backupPowerOk <= 1'b1;
    rdw(rtcwg_pkg::ADDR_MODE, 32'h0004_0000);
    apb(1'b1, rtcwg_pkg::ADDR_MODE, 32'h0065_0000);
    chkW(waveOutA, 1'b0);
    for (int j = 0; j < 2; j++) begin
      alarmEvent <= 1'b1;
      @(posedge clk_sys);
      alarmEvent <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chkW(waveOutA, 1 - j);
      chkW(waveOutB, 1'b1);
      rdw(rtcwg_pkg::ADDR_STAT, 32'h0000_0001);
      chkW(irq, j);
      apb(1'b1, rtcwg_pkg::ADDR_MASK, 1 - j);
      chkW(irq, 1 - j);
      apb(1'b1, rtcwg_pkg::ADDR_STAT, 32'h0000_0001);
      chkW(waveOutB, 1'b0);
      rdw(rtcwg_pkg::ADDR_STAT, 32'h0000_0000);
    end
    apb(1'b1, rtcwg_pkg::ADDR_MODE, 32'h0017_0000);
    chkW(waveLineSelB, 1'b1);
    repeat (50) @(posedge clk_sys);
    chkW(waveOutA, 1'b0);
    apb(1'b1, rtcwg_pkg::ADDR_MODE, 32'h0000_0000);
    chkW(waveLineSelA, 1'b0);
    repeat (400) @(posedge clk_sys);
    chkW({waveOutA, waveOutB}, 2'b00);
    apb(1'b1, rtcwg_pkg::ADDR_TIME, 32'h0000_0005);
    rdw(rtcwg_pkg::ADDR_TIME, 32'h0000_0000);
    results;
  end
endmodule : testbench
